/* rtl/pts_pkg.sv */
// Package for the peripheral trigger sequencer
package pts_pkg;
  localparam logic [3:0] CMD_CTRL = 4'h0;
  localparam logic [3:0] CMD_ADDCOPY = 4'h1;
  localparam logic [3:0] CMD_WAIT_RISE = 4'h4;
  localparam logic [3:0] CMD_WAIT_FALL = 4'h5;
  localparam logic [3:0] CMD_IRQ = 4'h7;
  localparam logic [3:0] OPT_SD_OFF = 4'h2;
  localparam logic [3:0] OPT_SD_ON = 4'h6;
  localparam logic [3:0] OPT_TMR_A = 4'h8;
  localparam logic [3:0] OPT_TMR_B = 4'h9;
  localparam logic [3:0] OPT_SWT = 4'hb;
  localparam logic [3:0] OPT_CH_CNT_A = 4'hc;
  localparam logic [3:0] OPT_CH_CNT_B = 4'hd;
  localparam logic [3:0] OPT_CH_LIT = 4'he;
  localparam logic [3:0] OPT_BCAST = 4'hf;
  // Register map, byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SWT = 8'h04;
  localparam logic [7:0] ADR_BTE = 8'h08;
  localparam logic [7:0] ADR_CNT_A_LIM = 8'h0c;
  localparam logic [7:0] ADR_CNT_B_LIM = 8'h10;
  localparam logic [7:0] ADR_TMR_A_LIM = 8'h14;
  localparam logic [7:0] ADR_TMR_B_LIM = 8'h18;
  localparam logic [7:0] ADR_SD_LIM = 8'h1c;
  localparam logic [7:0] ADR_LIT = 8'h20;
  localparam logic [7:0] ADR_HOLD = 8'h24;
  localparam logic [7:0] ADR_ADJ = 8'h28;
  localparam logic [7:0] ADR_QPTR = 8'h2c;
  localparam logic [7:0] ADR_CHAN = 8'h30;
  localparam logic [7:0] ADR_CNT_A = 8'h34;
  localparam logic [7:0] ADR_CNT_B = 8'h38;
  localparam logic [7:0] ADR_QUEUE = 8'h40;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SD_BIT = 1;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_TRIG = 32'h0000_0000;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_WAIT, ST_DELAY} pts_state_t;
endpackage

/* rtl/pts_sequencer.sv */
// Step-command interpreter for the peripheral trigger sequencer
//
// Contract
// [R1] Step byte: command high nibble, option low
// [R2] Command 0 runs control option
// [R3] Command 1 adds adjust to target
// [R4] Command 1 options 8+ copy hold
// [R5] Commands 001x write channel select field
// [R6] Commands 0100/0101 wait rising/falling edge
// [R7] Wait options 0-4 select PWM sources
// [R8] Options 7-13 select compare, capture, comparators
// [R9] Options 14/15 select ADC done, extint 2
// [R10] Reserved codes consumed as no-operation
// [R11] Command 0111 pulses interrupt 0 to 3
// [R12] Commands 100x pulse indexed trigger output
// [R13] Commands 101x jump to 5-bit target
// [R14] Commands 110x loop on counter a
// [R15] Commands 111x loop on counter b
// [R16] Control options 2/6 disable/enable step delay
// [R17] Control options 8/9 run timer to limit
// [R18] Control option 11 waits software trigger rise
// [R19] Control options 12-14 write channel register
// [R20] Control option 15 broadcasts enabled triggers
// [R21] Add/copy option selects limit or literal
// [R22] Outputs 0-11 feed compare/capture units
// [R23] Outputs 12-31 feed ADC, PWM, comparators, routing
// [R24] Step delay enabled: limit plus one clocks
// [R25] 5-bit pointer; two steps per word
// [R26] Queue contents survive reset
// [R27] Non-jump steps advance pointer by one
// [R28] Triggers and interrupts are one-cycle pulses
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module pts_sequencer
  import pts_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Wait sources
  input wire logic [15:0] event_in,
  // Peripheral side
  output logic [31:0] trig_out,
  output logic [3:0] irq_out,
  output logic [15:0] adc_channel_register
);
  typedef struct packed {
    pts_state_t st;
    logic ack;
    logic [31:0] rdat;
    logic run;
    logic sd_en;
    logic swt;
    logic [31:0] bte;
    logic [15:0] cnt_a_lim;
    logic [15:0] cnt_b_lim;
    logic [15:0] tmr_a_lim;
    logic [15:0] tmr_b_lim;
    logic [15:0] sd_lim;
    logic [15:0] lit;
    logic [15:0] hold;
    logic [15:0] adj;
    logic [4:0] qptr;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [15:0] tmr;
    logic [15:0] sd_cnt;
    logic [7:0] step;
    logic [15:0] ev_prev;
    logic swt_prev;
    logic [15:0] chan;
    logic [31:0] trig;
    logic [3:0] irq;
  } pts_regs_t;

  pts_regs_t r_reg;
  pts_regs_t r_next;
  logic [7:0] queue_mem [0:31];
  logic q_we;
  logic [4:0] q_wadr;
  logic [7:0] q_wdat;
  logic [7:0] fetch_byte;
  logic [3:0] cmd;
  logic [3:0] opt;
  logic [4:0] target;
  logic wr;
  logic rd;
  logic sel_lo;
  logic sel_hi;
  logic ev_rise;
  logic ev_fall;

  assign fetch_byte = queue_mem[r_reg.qptr];
  assign cmd = r_reg.step[7:4]; // [R1]
  assign opt = r_reg.step[3:0]; // [R1]
  assign target = {cmd[0], opt};
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !r_reg.ack;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !r_reg.ack;
  assign sel_lo = wb_sel_i[0];
  assign sel_hi = wb_sel_i[1];
  // Edge detect on option-selected source
  assign ev_rise = event_in[opt] && !r_reg.ev_prev[opt]; // [R7] [R8] [R9]
  assign ev_fall = !event_in[opt] && r_reg.ev_prev[opt];

  // Queue: no reset, survives every reset
  always_ff @(posedge sys_clk) begin
    if (q_we) begin // [R26]
      queue_mem[q_wadr] <= q_wdat;
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.trig = RST_TRIG; // [R28]
    r_next.irq = 4'h0; // [R28]
    r_next.ev_prev = event_in;
    r_next.swt_prev = r_reg.swt;
    q_we = 1'b0;
    q_wadr = 5'h00;
    q_wdat = 8'h00;
    // Bus writes
    if (wr) begin
      r_next.ack = 1'b1;
      if (wb_adr_i == ADR_CTRL) begin
        if (sel_lo) begin
          r_next.run = wb_dat_i[CTRL_RUN_BIT];
          r_next.sd_en = wb_dat_i[CTRL_SD_BIT];
        end
      end else if (wb_adr_i == ADR_SWT) begin
        if (sel_lo) begin
          r_next.swt = wb_dat_i[0]; // [R18]
        end
      end else if (wb_adr_i == ADR_BTE) begin
        r_next.bte = wb_dat_i;
      end else if (!r_reg.run) begin
        if (wb_adr_i == ADR_CNT_A_LIM && sel_lo && sel_hi) begin
          r_next.cnt_a_lim = wb_dat_i[15:0];
        end else if (wb_adr_i == ADR_CNT_B_LIM && sel_lo && sel_hi) begin
          r_next.cnt_b_lim = wb_dat_i[15:0];
        end else if (wb_adr_i == ADR_TMR_A_LIM && sel_lo && sel_hi) begin
          r_next.tmr_a_lim = wb_dat_i[15:0];
        end else if (wb_adr_i == ADR_TMR_B_LIM && sel_lo && sel_hi) begin
          r_next.tmr_b_lim = wb_dat_i[15:0];
        end else if (wb_adr_i == ADR_SD_LIM && sel_lo && sel_hi) begin
          r_next.sd_lim = wb_dat_i[15:0];
        end else if (wb_adr_i == ADR_LIT && sel_lo && sel_hi) begin
          r_next.lit = wb_dat_i[15:0];
        end else if (wb_adr_i == ADR_HOLD && sel_lo && sel_hi) begin
          r_next.hold = wb_dat_i[15:0];
        end else if (wb_adr_i == ADR_ADJ && sel_lo && sel_hi) begin
          r_next.adj = wb_dat_i[15:0];
        end else if (wb_adr_i == ADR_QPTR && sel_lo) begin
          r_next.qptr = wb_dat_i[4:0];
        end else if (wb_adr_i >= ADR_QUEUE && wb_adr_i[7:6] == 2'b01 && sel_lo) begin
          q_we = 1'b1;
          q_wadr = wb_adr_i[4:0];
          q_wdat = wb_dat_i[7:0];
        end
      end
    end
    // Bus reads
    if (rd) begin
      r_next.ack = 1'b1;
      r_next.rdat = 32'h0000_0000;
      if (wb_adr_i == ADR_CTRL) begin
        r_next.rdat = {29'h0000_0000, r_reg.st != ST_IDLE, r_reg.sd_en, r_reg.run};
      end else if (wb_adr_i == ADR_SWT) begin
        r_next.rdat = {31'h0000_0000, r_reg.swt};
      end else if (wb_adr_i == ADR_BTE) begin
        r_next.rdat = r_reg.bte;
      end else if (wb_adr_i == ADR_CNT_A_LIM) begin
        r_next.rdat = {16'h0000, r_reg.cnt_a_lim};
      end else if (wb_adr_i == ADR_CNT_B_LIM) begin
        r_next.rdat = {16'h0000, r_reg.cnt_b_lim};
      end else if (wb_adr_i == ADR_TMR_A_LIM) begin
        r_next.rdat = {16'h0000, r_reg.tmr_a_lim};
      end else if (wb_adr_i == ADR_TMR_B_LIM) begin
        r_next.rdat = {16'h0000, r_reg.tmr_b_lim};
      end else if (wb_adr_i == ADR_SD_LIM) begin
        r_next.rdat = {16'h0000, r_reg.sd_lim};
      end else if (wb_adr_i == ADR_LIT) begin
        r_next.rdat = {16'h0000, r_reg.lit};
      end else if (wb_adr_i == ADR_HOLD) begin
        r_next.rdat = {16'h0000, r_reg.hold};
      end else if (wb_adr_i == ADR_ADJ) begin
        r_next.rdat = {16'h0000, r_reg.adj};
      end else if (wb_adr_i == ADR_QPTR) begin
        r_next.rdat = {27'h000_0000, r_reg.qptr};
      end else if (wb_adr_i == ADR_CHAN) begin
        r_next.rdat = {16'h0000, r_reg.chan};
      end else if (wb_adr_i == ADR_CNT_A) begin
        r_next.rdat = {16'h0000, r_reg.cnt_a};
      end else if (wb_adr_i == ADR_CNT_B) begin
        r_next.rdat = {16'h0000, r_reg.cnt_b};
      end else if (wb_adr_i[7:6] == 2'b01 && wb_adr_i[5] == 1'b0) begin
        // Word view: even step low byte, odd step high byte
        r_next.rdat = {16'h0000, queue_mem[{wb_adr_i[4:1], 1'b1}],
                       queue_mem[{wb_adr_i[4:1], 1'b0}]}; // [R25]
      end
    end
    // Sequencer
    case (r_reg.st)
      ST_IDLE: begin
        if (r_reg.run) begin
          r_next.st = ST_FETCH;
          r_next.cnt_a = RST_WORD;
          r_next.cnt_b = RST_WORD;
        end
      end
      ST_FETCH: begin
        r_next.step = fetch_byte; // [R25]
        r_next.st = ST_EXEC;
        r_next.sd_cnt = RST_WORD;
        r_next.tmr = RST_WORD;
      end
      ST_EXEC: begin
        r_next.st = ST_DELAY;
        r_next.qptr = r_reg.qptr + 5'd1; // [R27] [R10]
        if (cmd == CMD_CTRL) begin // [R2]
          if (opt == OPT_SD_OFF) begin
            r_next.sd_en = 1'b0; // [R16]
          end else if (opt == OPT_SD_ON) begin
            r_next.sd_en = 1'b1; // [R16]
          end else if (opt == OPT_TMR_A || opt == OPT_TMR_B || opt == OPT_SWT) begin
            r_next.st = ST_WAIT; // [R17] [R18]
            r_next.qptr = r_reg.qptr;
          end else if (opt == OPT_CH_CNT_A) begin
            r_next.chan = r_reg.cnt_a; // [R19]
          end else if (opt == OPT_CH_CNT_B) begin
            r_next.chan = r_reg.cnt_b; // [R19]
          end else if (opt == OPT_CH_LIT) begin
            r_next.chan = r_reg.lit; // [R19]
          end else if (opt == OPT_BCAST) begin
            r_next.trig = r_reg.bte; // [R20]
          end
        end else if (cmd == CMD_ADDCOPY) begin
          if (!opt[3]) begin // [R3] [R21]
            case (opt[2:0])
              3'd0: r_next.cnt_a_lim = r_reg.cnt_a_lim + r_reg.adj;
              3'd1: r_next.cnt_b_lim = r_reg.cnt_b_lim + r_reg.adj;
              3'd2: r_next.tmr_a_lim = r_reg.tmr_a_lim + r_reg.adj;
              3'd3: r_next.tmr_b_lim = r_reg.tmr_b_lim + r_reg.adj;
              3'd4: r_next.sd_lim = r_reg.sd_lim + r_reg.adj;
              3'd5: r_next.lit = r_reg.lit + r_reg.adj;
              default: r_next.lit = r_reg.lit; // [R10]
            endcase
          end else begin // [R4] [R21]
            case (opt[2:0])
              3'd0: r_next.cnt_a_lim = r_reg.hold;
              3'd1: r_next.cnt_b_lim = r_reg.hold;
              3'd2: r_next.tmr_a_lim = r_reg.hold;
              3'd3: r_next.tmr_b_lim = r_reg.hold;
              3'd4: r_next.sd_lim = r_reg.hold;
              3'd5: r_next.lit = r_reg.hold;
              default: r_next.lit = r_reg.lit; // [R10]
            endcase
          end
        end else if (cmd[3:1] == 3'b001) begin
          r_next.chan = {r_reg.chan[15:5], target}; // [R5]
        end else if (cmd == CMD_WAIT_RISE || cmd == CMD_WAIT_FALL) begin
          if (opt != 4'h5 && opt != 4'h6) begin // [R7] [R10]
            r_next.st = ST_WAIT; // [R6]
            r_next.qptr = r_reg.qptr;
          end
        end else if (cmd == CMD_IRQ) begin
          if (opt[3:2] == 2'b00) begin
            r_next.irq[opt[1:0]] = 1'b1; // [R11]
          end
        end else if (cmd[3:1] == 3'b100) begin
          r_next.trig[target] = 1'b1; // [R12] [R22] [R23]
        end else if (cmd[3:1] == 3'b101) begin
          r_next.qptr = target; // [R13]
        end else if (cmd[3:1] == 3'b110) begin
          if (r_reg.cnt_a != r_reg.cnt_a_lim) begin // [R14]
            r_next.cnt_a = r_reg.cnt_a + 16'h0001;
            r_next.qptr = target;
          end
        end else if (cmd[3:1] == 3'b111) begin
          if (r_reg.cnt_b != r_reg.cnt_b_lim) begin // [R15]
            r_next.cnt_b = r_reg.cnt_b + 16'h0001;
            r_next.qptr = target;
          end
        end
      end
      ST_WAIT: begin
        r_next.sd_cnt = r_reg.sd_cnt + 16'h0001;
        if (cmd == CMD_CTRL && opt == OPT_SWT) begin
          if (r_reg.swt && !r_reg.swt_prev) begin // [R18]
            r_next.st = ST_DELAY;
            r_next.qptr = r_reg.qptr + 5'd1;
          end
        end else if (cmd == CMD_CTRL) begin
          if (r_reg.tmr == (opt[0] ? r_reg.tmr_b_lim : r_reg.tmr_a_lim)) begin // [R17]
            r_next.st = ST_DELAY;
            r_next.qptr = r_reg.qptr + 5'd1;
          end else begin
            r_next.tmr = r_reg.tmr + 16'h0001;
          end
        end else if ((cmd == CMD_WAIT_RISE && ev_rise) ||
                     (cmd == CMD_WAIT_FALL && ev_fall)) begin // [R6]
          r_next.st = ST_DELAY;
          r_next.qptr = r_reg.qptr + 5'd1;
        end
      end
      ST_DELAY: begin
        // With delay enabled, a non-wait step spans limit plus two clocks from exec
        if (!r_reg.sd_en || r_reg.sd_cnt >= r_reg.sd_lim) begin // [R24]
          r_next.st = r_reg.run ? ST_FETCH : ST_IDLE;
        end else begin
          r_next.sd_cnt = r_reg.sd_cnt + 16'h0001;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
    if (!r_reg.run && r_reg.st != ST_DELAY && r_reg.st != ST_EXEC) begin
      r_next.st = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.rdat;
  assign trig_out = r_reg.trig;
  assign irq_out = r_reg.irq;
  assign adc_channel_register = r_reg.chan;
endmodule

/* sim/pts_sequencer_sva.sv */
// Port assertions for the peripheral trigger sequencer
`timescale 1ns/1ps
module pts_sequencer_sva
  import pts_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Peripheral side
  input wire logic [31:0] trig_out,
  input wire logic [3:0] irq_out,
  input wire logic [15:0] adc_channel_register
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  trig_pulse_a: assert property (trig_out != 32'h0000_0000 |=> trig_out == 32'h0000_0000)
    else $error("trigger held");
  irq_pulse_a: assert property (irq_out != 4'h0 |=> irq_out == 4'h0)
    else $error("interrupt held");
  irq_onehot_a: assert property (irq_out != 4'h0 |-> $onehot(irq_out))
    else $error("several interrupts");
  step_exclusive_a: assert property (trig_out != 32'h0000_0000 |-> irq_out == 4'h0)
    else $error("trigger and interrupt together");
  chan_alone_a: assert property ($changed(adc_channel_register) |->
    trig_out == 32'h0000_0000 && irq_out == 4'h0)
    else $error("channel change with pulse");
  pulse_spacing_a: assert property (trig_out != 32'h0000_0000 || irq_out != 4'h0
    |=> (trig_out == 32'h0000_0000 && irq_out == 4'h0) [*2])
    else $error("pulses too close");
  chan_spacing_a: assert property ($changed(adc_channel_register)
    |=> $stable(adc_channel_register) [*2])
    else $error("channel changes too close");
endmodule
bind pts_sequencer pts_sequencer_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .trig_out(trig_out),
  .irq_out(irq_out), .adc_channel_register(adc_channel_register));

/* sim/pts_event_source.sv */
// Peripheral event model driving the wait sources
`timescale 1ns/1ps
module pts_event_source (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bench control
  input wire logic fire,
  input wire logic [3:0] src,
  // Events
  output logic [15:0] event_in
);
  typedef struct packed {
    logic [15:0] noise;
    logic [2:0] hold;
  } pts_src_t;
  pts_src_t s_reg;
  pts_src_t s_next;
  always_comb begin
    s_next = s_reg;
    s_next.noise = ~s_reg.noise;
    if (fire) begin
      s_next.hold = 3'h4;
    end else if (s_reg.hold != 3'h0) begin
      s_next.hold = s_reg.hold - 3'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  // Unselected sources toggle every cycle
  assign event_in = (s_reg.noise & ~(16'h0001 << src)) |
    ({15'h0000, s_reg.hold != 3'h0} << src);
endmodule

/* sim/tb_pts_sequencer.sv */
// Testbench for the peripheral trigger sequencer
`timescale 1ns/1ps
module tb_pts_sequencer
  import pts_pkg::*;
;
  logic sys_clk;
  logic rst_n;
  logic req;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [15:0] event_in;
  logic [31:0] trig_out;
  logic [3:0] irq_out;
  logic [15:0] adc_chan;
  logic fire;
  logic [3:0] src;
  logic [31:0] rd;
  logic saw_cnt_a;
  int n_errors;
  int n_tests;
  int trig_cnt [32];
  int irq_cnt [4];
  logic [7:0] prog [17] = '{8'h85, 8'h9F, 8'h72, 8'h75, 8'h60, 8'h18, 8'h10, 8'h80,
    8'hC7, 8'h0C, 8'h3A, 8'h4E, 8'h0F, 8'hAF, 8'h81, 8'h0E, 8'hB0};
  logic [7:0] prog2 [6] = '{8'h06, 8'h0B, 8'h08, 8'hE3, 8'h02, 8'hA5};
  pts_sequencer dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_in(event_in), .trig_out(trig_out),
    .irq_out(irq_out), .adc_channel_register(adc_chan));
  pts_event_source u_src (.sys_clk(sys_clk), .rst_n(rst_n), .fire(fire), .src(src),
    .event_in(event_in));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Pulse tally, sampled mid-cycle
  always @(negedge sys_clk) begin
    for (int i = 0; i < 32; i++) if (trig_out[i] === 1'b1) trig_cnt[i]++;
    for (int i = 0; i < 4; i++) if (irq_out[i] === 1'b1) irq_cnt[i]++;
    if (adc_chan === 16'h0002) saw_cnt_a = 1'b1;
  end
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    input logic [3:0] sel);
    int k;
    k = 0;
    @(posedge sys_clk);
    req <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    wb_sel <= sel;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      complete_run();
    end
    rd = wb_dat_o;
    req <= 1'b0;
  endtask
  task automatic wait_ptr(input logic [4:0] p);
    int k;
    for (k = 0; k < 300; k++) begin
      wb(1'b0, ADR_QPTR, 32'h0000_0000, 4'hF);
      if (rd[4:0] === p) break;
    end
    if (k >= 300) begin
      n_errors++;
      complete_run();
    end
  endtask
  initial begin
    n_errors = 0;
    n_tests = 0;
    saw_cnt_a = 1'b0;
    rst_n = 1'b0;
    req = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0000_0000;
    fire = 1'b0;
    src = 4'hE;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    wb(1'b0, ADR_QPTR, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0000);
    wb(1'b1, 8'hFC, 32'h0000_FFFF, 4'hF);
    wb(1'b0, 8'hFC, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0000);
    for (int i = 0; i < 17; i++) wb(1'b1, ADR_QUEUE + 8'(i), {24'h00_0000, prog[i]}, 4'h1);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    wb(1'b0, ADR_QUEUE, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_9F85);
    wb(1'b1, ADR_HOLD, 32'h0000_0001, 4'hF);
    wb(1'b1, ADR_ADJ, 32'h0000_0001, 4'hF);
    wb(1'b1, ADR_LIT, 32'h0000_1234, 4'hF);
    wb(1'b1, ADR_BTE, 32'h0000_F000, 4'hF);
    wb(1'b1, ADR_CTRL, 32'h0000_0001, 4'hF);
    wait_ptr(5'd11);
    repeat (20) @(posedge sys_clk);
    wb(1'b0, ADR_QPTR, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_000B);
    check({16'h0000, adc_chan}, 32'h0000_001A);
    check(trig_cnt[5], 1);
    check(trig_cnt[31], 1);
    check(trig_cnt[0], 3);
    check(irq_cnt[2], 1);
    check(irq_cnt[0] + irq_cnt[1] + irq_cnt[3], 0);
    check(saw_cnt_a, 1'b1);
    wb(1'b0, ADR_CNT_A, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0002);
    wb(1'b0, ADR_CNT_A_LIM, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0002);
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    wait_ptr(5'd16);
    for (int i = 12; i < 16; i++) check(trig_cnt[i], 1);
    check(trig_cnt[1], 0);
    check({16'h0000, adc_chan}, 32'h0000_1234);
    // Second program: delay, software trigger, timer, loop b
    wb(1'b1, ADR_CTRL, 32'h0000_0000, 4'hF);
    repeat (10) @(posedge sys_clk);
    wb(1'b1, ADR_TMR_A_LIM, 32'h0000_0005, 4'hF);
    wb(1'b1, ADR_CNT_B_LIM, 32'h0000_0001, 4'hF);
    wb(1'b1, ADR_SD_LIM, 32'h0000_0003, 4'hF);
    wb(1'b1, ADR_QPTR, 32'h0000_0000, 4'hF);
    for (int i = 0; i < 6; i++) wb(1'b1, ADR_QUEUE + 8'(i), {24'h00_0000, prog2[i]}, 4'h1);
    wb(1'b1, ADR_CTRL, 32'h0000_0001, 4'hF);
    wait_ptr(5'd1);
    repeat (20) @(posedge sys_clk);
    wb(1'b0, ADR_QPTR, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0001);
    wb(1'b0, ADR_CTRL, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0007);
    wb(1'b1, ADR_SWT, 32'h0000_0001, 4'hF);
    wait_ptr(5'd5);
    wb(1'b0, ADR_CNT_B, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0001);
    wb(1'b0, ADR_CTRL, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0005);
    complete_run();
  end
endmodule
